// ---- include/scmdi_regs.vh ----
`ifndef SCMDI_REGS_VH
`define SCMDI_REGS_VH
// ----------------------------------------------------------------
// serial line timing
// ----------------------------------------------------------------
`define SCMDI_CLK_HZ 100000000
`define SCMDI_BAUD 9600
`define SCMDI_BIT_CYC (`SCMDI_CLK_HZ / `SCMDI_BAUD)
`define SCMDI_HALF_CYC (`SCMDI_BIT_CYC / 2)
`define SCMDI_DATA_BITS 8
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define SCMDI_CMD_STATUS 8'hCC
`define SCMDI_CMD_PWR_ON 8'hCE
`define SCMDI_CMD_PWR_OFF 8'hCF
`define SCMDI_CMD_ONLINE 8'hEE
`define SCMDI_CMD_LOCAL 8'hEF
`define SCMDI_CMD_RESET 8'hFB
`define SCMDI_CMD_CONFIG 8'hFD
`define SCMDI_CR 8'h0D
`define SCMDI_POS_MAX 4'h9
// ----------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------
`define SCMDI_WHEEL_BIT 7
`define SCMDI_SPEED_HI 6
`define SCMDI_SPEED_LO 4
`define SCMDI_POS_HI 3
`define SCMDI_POS_LO 0
// ----------------------------------------------------------------
// configuration reply
// ----------------------------------------------------------------
`define SCMDI_CFG_LEN 4'hE
`define SCMDI_CFG_LAST 4'hD
`define SCMDI_CFG_CTRL_AT 4'h1
`define SCMDI_CFG_WHEEL_AT 4'h5
`define SCMDI_CFG_STEP_AT 4'h9
`endif

// ---- rtl/scmdi_core.v ----
`timescale 1ns/1ps
// Overview of operation
// - config reply opens with echo 253
// - config reply is fourteen bytes long
// - config reply ends with carriage return
// - bit seven selects the wheel
// - bits six to four give speed
// - low nibble position, above nine not filter
// - specials only among non-filter byte patterns
// - echo every received byte immediately
// - send carriage return after completion
// - serial and usb behave the same
// - serial source at reset and on-line key
// - usb command selects usb, serial reverts
// - 9600 baud, 8N1, no flow control
// - only data lines, no handshake used
// - decode status, power, line, reset, config
// - local mode ignores all but on-line
`include "scmdi_regs.vh"
module scmdi_core #(
  parameter BIT_CYC = `SCMDI_BIT_CYC,
  parameter [31:0] CFG_CTRL_TXT = 32'h43545231, // arbitrary text
  parameter [31:0] CFG_WHEEL_TXT = 32'h57484C31, // arbitrary text
  parameter [31:0] CFG_STEP_TXT = 32'h53544531 // arbitrary text
) (
  input wire ref_clk,
  input wire rst_n,
  input wire ser_rxd,
  output reg ser_txd,
  input wire usb_rx_valid,
  input wire [7:0] usb_rx_data,
  input wire usb_tx_ready,
  output reg usb_tx_valid,
  output reg [7:0] usb_tx_data,
  input wire key_online,
  input wire key_local,
  input wire op_done,
  output reg src_usb,
  output reg local_mode,
  output reg filt_valid,
  output reg filt_wheel,
  output reg [2:0] filt_speed,
  output reg [3:0] filt_pos,
  output reg motor_power,
  output reg status_req,
  output reg reset_req,
  output reg busy
);
  // ----------------------------------------------------------------
  // serial receiver
  // ----------------------------------------------------------------
  localparam [2:0] RX_IDLE = 3'h1;
  localparam [2:0] RX_DATA = 3'h2;
  localparam [2:0] RX_STOP = 3'h4;
  // counters are 16 bits wide, so the cycle count is cut on purpose
  localparam [31:0] CYC_W = BIT_CYC;
  localparam [15:0] BIT_LAST = CYC_W[15:0] - 16'h0001;
  localparam [15:0] HALF = CYC_W[16:1];
  reg [2:0] rx_state;
  reg [15:0] rx_cnt;
  reg [2:0] rx_bit;
  reg [7:0] rx_shift;
  reg rx_strobe;
  reg [7:0] rx_byte;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_strobe <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_strobe <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          // half bit wait confirms a real start edge
          if (!ser_rxd) begin
            if (rx_cnt == HALF) begin
              rx_cnt <= 16'h0000;
              rx_state <= RX_DATA; // bit count has wrapped back to zero
            end else begin
              rx_cnt <= rx_cnt + 16'h0001;
            end
          end else begin
            rx_cnt <= 16'h0000;
          end
        end
        RX_DATA: begin
          if (rx_cnt == BIT_LAST) begin
            rx_cnt <= 16'h0000;
            rx_shift <= {ser_rxd, rx_shift[7:1]}; // lsb first
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= RX_STOP;
            end
          end else begin
            rx_cnt <= rx_cnt + 16'h0001;
          end
        end
        RX_STOP: begin
          if (rx_cnt == BIT_LAST) begin
            rx_cnt <= 16'h0000;
            rx_state <= RX_IDLE;
            // framing error drops the byte silently
            if (ser_rxd) begin
              rx_strobe <= 1'b1;
              rx_byte <= rx_shift;
            end
          end else begin
            rx_cnt <= rx_cnt + 16'h0001;
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire in_ser = rx_strobe;
  wire in_usb = usb_rx_valid & ~rx_strobe; // serial wins a same-cycle clash
  wire in_any = in_ser | in_usb;
  wire [7:0] in_byte = in_ser ? rx_byte : usb_rx_data;
  // nibble above nine not a filter
  wire is_filt = in_byte[`SCMDI_POS_HI:`SCMDI_POS_LO] <= `SCMDI_POS_MAX;
  wire is_online = ~is_filt & (in_byte == `SCMDI_CMD_ONLINE);
  wire is_spec = ~is_filt & ((in_byte == `SCMDI_CMD_STATUS) |
    (in_byte == `SCMDI_CMD_PWR_ON) | (in_byte == `SCMDI_CMD_PWR_OFF) |
    is_online | (in_byte == `SCMDI_CMD_LOCAL) |
    (in_byte == `SCMDI_CMD_RESET) | (in_byte == `SCMDI_CMD_CONFIG));
  wire act = in_any & (~local_mode | is_online);
  wire valid_cmd = act & (is_filt | is_spec);

  // ----------------------------------------------------------------
  // transmit queue: echo, then reply bytes, then carriage return
  // ----------------------------------------------------------------
  localparam [3:0] TS_IDLE = 4'h1;
  localparam [3:0] TS_CFG = 4'h2;
  localparam [3:0] TS_WAIT = 4'h4;
  localparam [3:0] TS_CR = 4'h8;
  reg [3:0] ts_state;
  reg [3:0] cfg_idx;
  reg echo_pend;
  reg [7:0] echo_byte;
  reg tx_busy;
  reg [15:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_frame;
  reg reply_usb;

  wire [95:0] cfg_txt = {CFG_CTRL_TXT, CFG_WHEEL_TXT, CFG_STEP_TXT};
  // text leaves most significant byte first, one byte per index step
  wire [95:0] cfg_shift = cfg_txt << {cfg_idx - `SCMDI_CFG_CTRL_AT, 3'h0};
  wire [7:0] cfg_byte = (cfg_idx == `SCMDI_CFG_LAST) ? `SCMDI_CR : cfg_shift[95:88];

  // one byte sender shared by both ports keeps the protocol identical
  wire tx_free = reply_usb ? ~usb_tx_valid : ~tx_busy;
  wire send_echo = echo_pend & tx_free;
  wire send_cfg = ~echo_pend & tx_free & (ts_state == TS_CFG);
  wire send_cr = ~echo_pend & tx_free & (ts_state == TS_CR);
  wire send = send_echo | send_cfg | send_cr;
  wire [7:0] send_byte = send_echo ? echo_byte : (send_cfg ? cfg_byte : `SCMDI_CR);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_pend <= 1'b0;
      echo_byte <= 8'h00;
      reply_usb <= 1'b0;
    end else begin
      if (in_any) begin
        echo_pend <= 1'b1; // a newer byte overwrites, host waits per command
        echo_byte <= in_byte;
        reply_usb <= in_usb;
      end else if (send_echo) begin
        echo_pend <= 1'b0;
      end
    end
  end

  // reply sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ts_state <= TS_IDLE;
      cfg_idx <= 4'h0;
      busy <= 1'b0;
    end else begin
      case (ts_state)
        TS_IDLE: begin
          if (act & is_spec & (in_byte == `SCMDI_CMD_CONFIG)) begin
            cfg_idx <= `SCMDI_CFG_CTRL_AT;
            ts_state <= TS_CFG;
            busy <= 1'b1;
          end else if (valid_cmd) begin
            ts_state <= is_filt ? TS_WAIT : TS_CR;
            busy <= 1'b1;
          end
        end
        TS_CFG: begin
          if (send_cfg) begin
            cfg_idx <= cfg_idx + 4'h1;
            if (cfg_idx == `SCMDI_CFG_LAST) begin
              ts_state <= TS_IDLE;
              busy <= 1'b0;
            end
          end
        end
        TS_WAIT: begin
          // motion completes outside this block
          if (op_done) begin
            ts_state <= TS_CR;
          end
        end
        TS_CR: begin
          if (send_cr) begin
            ts_state <= TS_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          ts_state <= TS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // byte transmitters
  // ----------------------------------------------------------------
  // 8N1 transmit framing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_frame <= 10'h3FF;
      ser_txd <= 1'b1;
      usb_tx_valid <= 1'b0;
      usb_tx_data <= 8'h00;
    end else begin
      if (usb_tx_valid & usb_tx_ready) begin
        usb_tx_valid <= 1'b0;
      end
      if (send & reply_usb) begin
        usb_tx_valid <= 1'b1;
        usb_tx_data <= send_byte;
      end
      if (send & ~reply_usb) begin
        tx_busy <= 1'b1;
        tx_frame <= {1'b1, send_byte, 1'b0};
        tx_cnt <= 16'h0000;
        tx_bit <= 4'h0;
        ser_txd <= 1'b0;
      end else if (tx_busy) begin
        if (tx_cnt == BIT_LAST) begin
          tx_cnt <= 16'h0000;
          tx_bit <= tx_bit + 4'h1;
          if (tx_bit == 4'h9) begin
            tx_busy <= 1'b0;
            ser_txd <= 1'b1;
          end else begin
            ser_txd <= tx_frame[tx_bit + 4'h1];
          end
        end else begin
          tx_cnt <= tx_cnt + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // command effects and source tracking
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_usb <= 1'b0;
      local_mode <= 1'b0;
      filt_valid <= 1'b0;
      filt_wheel <= 1'b0;
      filt_speed <= 3'h0;
      filt_pos <= 4'h0;
      motor_power <= 1'b0;
      status_req <= 1'b0;
      reset_req <= 1'b0;
    end else begin
      filt_valid <= 1'b0;
      status_req <= 1'b0;
      reset_req <= 1'b0;
      if (key_online) begin
        src_usb <= 1'b0;
        local_mode <= 1'b0;
      end else if (key_local) begin
        local_mode <= 1'b1;
      end else if (valid_cmd) begin
        src_usb <= in_usb;
        if (is_filt) begin
          filt_valid <= 1'b1;
          filt_wheel <= in_byte[`SCMDI_WHEEL_BIT];
          filt_speed <= in_byte[`SCMDI_SPEED_HI:`SCMDI_SPEED_LO];
          filt_pos <= in_byte[`SCMDI_POS_HI:`SCMDI_POS_LO];
        end else begin
          case (in_byte)
            `SCMDI_CMD_STATUS: status_req <= 1'b1;
            `SCMDI_CMD_PWR_ON: motor_power <= 1'b1;
            `SCMDI_CMD_PWR_OFF: motor_power <= 1'b0;
            `SCMDI_CMD_ONLINE: local_mode <= 1'b0;
            `SCMDI_CMD_LOCAL: local_mode <= 1'b1;
            `SCMDI_CMD_RESET: reset_req <= 1'b1;
            default: status_req <= 1'b0;
          endcase
        end
      end
    end
  end

endmodule

// ---- test/scmdi_core_sva.sv ----
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module scmdi_core_sva (
  input wire ref_clk,
  input wire rst_n,
  input wire usb_rx_valid,
  input wire [7:0] usb_rx_data,
  input wire usb_tx_ready,
  input wire usb_tx_valid,
  input wire [7:0] usb_tx_data,
  input wire key_online,
  input wire key_local,
  input wire src_usb,
  input wire local_mode,
  input wire filt_valid,
  input wire [3:0] filt_pos,
  input wire status_req,
  input wire reset_req,
  input wire busy
);
  reg [7:0] last_rx;
  // last usb byte kept so the echo compare needs no deep history
  always @(posedge ref_clk) begin
    if (usb_rx_valid) begin
      last_rx <= usb_rx_data;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence usb_in;
    usb_rx_valid && !busy && !usb_tx_valid;
  endsequence
  sequence usb_echo;
    ##[1:3] (usb_tx_valid && usb_tx_data == last_rx);
  endsequence
  usb_echo_a: assert property (usb_in |-> usb_echo)
    else $error("usb byte not echoed");
  pos_range_a: assert property (filt_valid |-> filt_pos <= 4'h9)
    else $error("filter position above nine");
  filt_pulse_a: assert property (filt_valid |-> busy ##1 !filt_valid)
    else $error("filter strobe not a single busy pulse");
  status_pulse_a: assert property (status_req |=> !status_req)
    else $error("status request longer than one cycle");
  reset_pulse_a: assert property (reset_req |=> !reset_req)
    else $error("reset request longer than one cycle");
  local_key_a: assert property (key_local && !key_online |=> local_mode)
    else $error("local key did not enter local mode");
  online_key_a: assert property (key_online |=> !local_mode && !src_usb)
    else $error("on-line key did not restore serial source");
  usb_hold_a: assert property (
    usb_tx_valid && !usb_tx_ready |=> usb_tx_valid && $stable(usb_tx_data))
    else $error("usb output changed before ready");
  local_quiet_a: assert property (
    local_mode && $past(local_mode) && $past(local_mode, 2) |-> !filt_valid && !status_req)
    else $error("command acted on in local mode");
endmodule
bind scmdi_core scmdi_core_sva chk (
  .ref_clk, .rst_n, .usb_rx_valid, .usb_rx_data, .usb_tx_ready, .usb_tx_valid,
  .usb_tx_data, .key_online, .key_local, .src_usb, .local_mode, .filt_valid, .filt_pos,
  .status_req, .reset_req, .busy
);

// ---- test/scmdi_host.sv ----
`timescale 1ns/1ps
// ------------------------------
// serial host model
// ------------------------------
module scmdi_host #(
  parameter int BIT_CYC = 16
) (
  input wire ref_clk,
  input wire txd,
  output reg rxd
);
  logic [7:0] q [$];
  logic [7:0] b;
  int i;
  initial rxd = 1'b1;
  // 8N1 lsb first, data line only
  task automatic send(input logic [7:0] v);
    @(posedge ref_clk);
    #1;
    for (int k = 0; k < 10; k++) begin
      rxd = (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : v[k-1];
      repeat (BIT_CYC) @(posedge ref_clk);
      #1;
    end
  endtask
  // receiver samples mid bit, no flow control
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge ref_clk);
    q.push_back(b);
  end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
// ------------------------------
// command interpreter bench
// ------------------------------
module tb_top;
  localparam int BC = 16;
  localparam [31:0] C1 = 32'h41424344; // arbitrary text
  localparam [31:0] C2 = 32'h45464748; // arbitrary text
  localparam [31:0] C3 = 32'h494A4B4C; // arbitrary text
  localparam [111:0] CFG = {8'hFD, C1, C2, C3, 8'h0D};
  typedef struct packed {
    logic [7:0] cmd;
    logic filt;
    logic [2:0] spd;
    logic [3:0] pos;
    logic cr;
    logic pwr;
  } scmdi_row_t;
  // command, filter flag, speed, position, done byte, motor power after
  scmdi_row_t rows [9] = '{
    '{8'h23, 1'b1, 3'h2, 4'h3, 1'b1, 1'b0},
    '{8'hCE, 1'b0, 3'h0, 4'h0, 1'b1, 1'b1},
    '{8'h79, 1'b1, 3'h7, 4'h9, 1'b1, 1'b1},
    '{8'h0A, 1'b0, 3'h0, 4'h0, 1'b0, 1'b1},
    '{8'hCF, 1'b0, 3'h0, 4'h0, 1'b1, 1'b0},
    '{8'hCC, 1'b0, 3'h0, 4'h0, 1'b1, 1'b0},
    '{8'hFB, 1'b0, 3'h0, 4'h0, 1'b1, 1'b0},
    '{8'hEE, 1'b0, 3'h0, 4'h0, 1'b1, 1'b0},
    '{8'h00, 1'b1, 3'h0, 4'h0, 1'b1, 1'b0}
  };
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic usb_rx_valid = 1'b0;
  logic [7:0] usb_rx_data = 8'h00;
  logic usb_tx_ready = 1'b0;
  logic key_online = 1'b0;
  logic key_local = 1'b0;
  logic op_done = 1'b0;
  wire ser_rxd, ser_txd, usb_tx_valid, src_usb, local_mode, filt_valid, filt_wheel;
  wire motor_power, status_req, reset_req, busy;
  wire [7:0] usb_tx_data;
  wire [2:0] filt_speed;
  wire [3:0] filt_pos;
  logic saw_f, saw_s, saw_r;
  logic [7:0] cap;
  logic [7:0] d;
  int err_total = 0;
  int n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  scmdi_core #(.BIT_CYC(BC), .CFG_CTRL_TXT(C1), .CFG_WHEEL_TXT(C2), .CFG_STEP_TXT(C3)) uut (
    .ref_clk, .rst_n, .ser_rxd, .ser_txd, .usb_rx_valid, .usb_rx_data, .usb_tx_ready,
    .usb_tx_valid, .usb_tx_data, .key_online, .key_local, .op_done, .src_usb, .local_mode,
    .filt_valid, .filt_wheel, .filt_speed, .filt_pos, .motor_power, .status_req,
    .reset_req, .busy
  );
  scmdi_host #(.BIT_CYC(BC)) host (.ref_clk, .txd(ser_txd), .rxd(ser_rxd));
  // latch strobes so one-cycle pulses are not missed between checks
  always @(posedge ref_clk) begin
    if (filt_valid === 1'b1) begin
      saw_f <= 1'b1;
      cap <= {filt_wheel, filt_speed, filt_pos};
    end
    if (status_req === 1'b1) saw_s <= 1'b1;
    if (reset_req === 1'b1) saw_r <= 1'b1;
  end
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // bounded waits: a byte that never comes ends the run as a mismatch
  task automatic get_ser(output logic [7:0] v);
    for (int k = 0; k < 40 * BC && host.q.size() == 0; k++) @(posedge ref_clk);
    if (host.q.size() == 0) begin
      err_total++;
      report_and_stop();
    end else v = host.q.pop_front();
  endtask
  // sink stalls three cycles before taking each byte
  task automatic get_usb(output logic [7:0] v);
    for (int k = 0; k < 400 && usb_tx_valid !== 1'b1; k++) @(posedge ref_clk);
    if (usb_tx_valid !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    repeat (3) @(posedge ref_clk);
    #1 usb_tx_ready = 1'b1;
    @(posedge ref_clk);
    v = usb_tx_data;
    #1 usb_tx_ready = 1'b0;
  endtask
  task automatic usb_send(input logic [7:0] v);
    #1 usb_rx_data = v;
    usb_rx_valid = 1'b1;
    tick(1);
    usb_rx_valid = 1'b0;
  endtask
  task automatic run_row(input scmdi_row_t r);
    saw_f = 1'b0;
    saw_s = 1'b0;
    saw_r = 1'b0;
    host.send(r.cmd);
    get_ser(d);
    check("echo", r.cmd, d);
    check("filter seen", r.filt, saw_f);
    if (r.filt) begin
      check("fields", {1'b0, r.spd, r.pos}, cap);
      #1 op_done = 1'b1;
      tick(1);
      op_done = 1'b0;
    end
    if (r.cr) begin
      get_ser(d);
      check("done byte", 8'h0D, d);
    end else begin
      tick(30 * BC);
      check("silent", 1'b0, host.q.size() != 0);
    end
    check("status", r.cmd == 8'hCC, saw_s);
    check("reset", r.cmd == 8'hFB, saw_r);
    check("power", r.pwr, motor_power);
    check("busy", 1'b0, busy);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    check("idle line", 1'b1, ser_txd);
    check("source", 1'b0, src_usb);
    foreach (rows[i]) run_row(rows[i]);
    // configuration reply byte by byte, then nothing more
    host.send(8'hFD);
    for (int k = 0; k < 14; k++) begin
      get_ser(d);
      check("config", CFG[111 - 8 * k -: 8], d);
    end
    tick(30 * BC);
    check("config len", 1'b0, host.q.size() != 0);
    // local mode by command, ignored filter byte, keys, on-line command
    run_row(scmdi_row_t'{8'hEF, 1'b0, 3'h0, 4'h0, 1'b1, 1'b0});
    check("local cmd", 1'b1, local_mode);
    run_row(scmdi_row_t'{8'h24, 1'b0, 3'h0, 4'h0, 1'b0, 1'b0});
    key_online = 1'b1;
    tick(1);
    key_online = 1'b0;
    tick(1);
    check("online key", 1'b0, local_mode);
    key_local = 1'b1;
    tick(1);
    key_local = 1'b0;
    tick(1);
    check("local key", 1'b1, local_mode);
    run_row(rows[7]);
    check("online cmd", 1'b0, local_mode);
    // usb filter command, then serial takes the source back
    run_row(rows[1]);
    usb_send(8'h45);
    get_usb(d);
    check("usb echo", 8'h45, d);
    check("usb source", 1'b1, src_usb);
    check("usb fields", 8'h45, cap);
    op_done = 1'b1;
    tick(1);
    op_done = 1'b0;
    get_usb(d);
    check("usb done", 8'h0D, d);
    run_row(rows[2]);
    check("serial source", 1'b0, src_usb);
    // second reset in mid-run clears motor power
    #1 rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    check("reset power", 1'b0, motor_power);
    check("reset line", 1'b1, ser_txd);
    report_and_stop();
  end
endmodule
